// >>> src/fan_regs.vh
// Register offsets, field positions and reset values for the fan alarm bank
`ifndef FAN_REGS_VH
`define FAN_REGS_VH
// Printed indices (not multiples of four): byte address = 4 * index
`define FAN_IDX_ALARM_STATUS   8'h5A
`define FAN_IDX_NVM_XFER_CTRL  8'h5B
`define FAN_ADDR_ALARM_STATUS  10'h168
`define FAN_ADDR_NVM_XFER_CTRL 10'h16C
`define FAN_ADDR_MODE          10'h170
`define FAN_ADDR_XFER_STATUS   10'h174
// Alarm status fields
`define FAN_ST_REMOTE_HIGH     3
`define FAN_ST_REMOTE_OT       2
`define FAN_ST_FAN_B           1
`define FAN_ST_FAN_A           0
// Transfer control fields
`define FAN_XC_DIR             7
`define FAN_XC_BLK_MSB         4
`define FAN_XC_BLK_LSB         0
// Mode register fields
`define FAN_MD_FAN_A_RD        0
`define FAN_MD_FAN_B_RD        1
// Reset values
`define FAN_RST_ALARM_STATUS   8'h00
`define FAN_RST_NVM_XFER_CTRL  8'h00
`define FAN_RST_MODE           2'h0
// Transfer geometry
`define FAN_BLOCK_BYTES        5'h10
`define FAN_BLOCK_COUNT        3'h5
`endif

// >>> src/fan_chan_alarm.v
// One fan channel fault detector: tach count versus threshold, or running level
`timescale 1ns/1ns
`default_nettype none
module fan_chan_alarm #(
   parameter CW = 16
) (
   // Clock and reset
   input  wire          i_ref_clk,
   input  wire          i_srst,
   // Channel inputs
   input  wire          i_rd_mode,
   input  wire [CW-1:0] i_count,
   input  wire [CW-1:0] i_threshold,
   input  wire          i_count_valid,
   input  wire          i_overflow,
   input  wire          i_stopped,
   input  wire          i_running,
   // Fault level
   output reg           o_fault
);
   reg fault_next;
   always @* begin
      if (i_rd_mode)
         fault_next = ~i_running;
      else if (i_count_valid)
         fault_next = (i_count > i_threshold) | i_overflow | i_stopped;
      else
         fault_next = o_fault | i_stopped;
   end
   always @(posedge i_ref_clk) begin
      if (i_srst)
         o_fault <= 1'b0;
      else
         o_fault <= fault_next;
   end
endmodule // fan_chan_alarm
`default_nettype wire

// >>> src/fan_alarm_bank.v
// Alarm status and NVM transfer control registers behind an APB slave
//
// Our own choice: the APB slave port.
`timescale 1ns/1ns
`default_nettype none
`include "fan_regs.vh"
// Functional notes
// - Remote above high set point sets bit 3
// - Remote above overtemp set point sets bit 2
// - Fan B count within threshold reads 0
// - Fan A count within threshold reads 0
// - Running-detect mode: running reads 0
// - Slow, stopped or overflow sets fan alarm (code: in running-detect mode only a low running level sets it)
// - Bit 7 selects load or write direction
// - Bits 0-4 select 16-byte blocks
// - Status alarm flags clear on read
// - Persisting fault sets flag again
module fan_alarm_bank #(
   parameter TW = 12,
   parameter CW = 16
) (
   // Clock and reset
   input  wire          i_ref_clk,
   input  wire          i_srst,
   // APB slave
   input  wire          i_psel,
   input  wire          i_penable,
   input  wire          i_pwrite,
   input  wire [11:0]   i_paddr,
   input  wire [31:0]   i_pwdata,
   output reg  [31:0]   o_prdata,
   output reg           o_pready,
   output reg           o_pslverr,
   // Temperature inputs (signed)
   input  wire [TW-1:0] i_remote_temp,
   input  wire [TW-1:0] i_remote_high_setpt,
   input  wire [TW-1:0] i_remote_ot_setpt,
   // Fan channel A
   input  wire [CW-1:0] i_fan_a_count,
   input  wire          i_fan_a_count_valid,
   input  wire          i_fan_a_overflow,
   input  wire          i_fan_a_stopped,
   input  wire          i_fan_a_speed_input,
   // Fan channel B
   input  wire [CW-1:0] i_fan_b_count,
   input  wire          i_fan_b_count_valid,
   input  wire          i_fan_b_overflow,
   input  wire          i_fan_b_stopped,
   input  wire          i_fan_b_speed_input,
   input  wire [CW-1:0] i_tach_threshold,
   // NVM transfer engine
   input  wire          i_nvm_ready,
   output reg           o_nvm_req,
   output reg           o_nvm_load,
   output reg  [6:0]    o_nvm_addr
);
   localparam ST_IDLE = 3'b001;
   localparam ST_MOVE = 3'b010;
   localparam ST_NEXT = 3'b100;

   reg  [7:0] alarm_status_reg;
   reg  [7:0] alarm_status_next;
   reg  [7:0] nvm_xfer_ctrl_reg;
   reg  [1:0] mode_reg;
   reg  [2:0] state_reg;
   reg  [4:0] blk_mask_reg;
   reg  [2:0] blk_reg;
   reg  [3:0] byte_reg;
   reg        remote_high_reg;
   reg        remote_ot_reg;
   wire       fan_a_fault;
   wire       fan_b_fault;
   wire       access;
   wire       rd_status;
   wire       rd_ctrl;
   wire       wr_ctrl;
   wire       mapped;

   // Aliases above the register page are refused, so they must not clear or write
   assign access    = i_psel & i_penable & o_pready & (i_paddr[11:10] == 2'h0);
   assign rd_status = access & ~i_pwrite & (i_paddr[9:0] == `FAN_ADDR_ALARM_STATUS);
   assign rd_ctrl   = access & ~i_pwrite & (i_paddr[9:0] == `FAN_ADDR_NVM_XFER_CTRL);
   assign wr_ctrl   = access & i_pwrite & (i_paddr[9:0] == `FAN_ADDR_NVM_XFER_CTRL);
   assign mapped    = (i_paddr[11:10] == 2'h0) &
                      ((i_paddr[9:0] == `FAN_ADDR_ALARM_STATUS) |
                       (i_paddr[9:0] == `FAN_ADDR_NVM_XFER_CTRL) |
                       (i_paddr[9:0] == `FAN_ADDR_MODE) |
                       (i_paddr[9:0] == `FAN_ADDR_XFER_STATUS));

   fan_chan_alarm #(.CW(CW)) u_fan_a (
      .i_ref_clk     (i_ref_clk),
      .i_srst        (i_srst),
      .i_rd_mode     (mode_reg[`FAN_MD_FAN_A_RD]),
      .i_count       (i_fan_a_count),
      .i_threshold   (i_tach_threshold),
      .i_count_valid (i_fan_a_count_valid),
      .i_overflow    (i_fan_a_overflow),
      .i_stopped     (i_fan_a_stopped),
      .i_running     (i_fan_a_speed_input),
      .o_fault       (fan_a_fault)
   );

   fan_chan_alarm #(.CW(CW)) u_fan_b (
      .i_ref_clk     (i_ref_clk),
      .i_srst        (i_srst),
      .i_rd_mode     (mode_reg[`FAN_MD_FAN_B_RD]),
      .i_count       (i_fan_b_count),
      .i_threshold   (i_tach_threshold),
      .i_count_valid (i_fan_b_count_valid),
      .i_overflow    (i_fan_b_overflow),
      .i_stopped     (i_fan_b_stopped),
      .i_running     (i_fan_b_speed_input),
      .o_fault       (fan_b_fault)
   );

   // Temperature compare registered so all flags see the same two-cycle latency
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         remote_high_reg <= 1'b0;
         remote_ot_reg   <= 1'b0;
      end else begin
         remote_high_reg <= $signed(i_remote_temp) > $signed(i_remote_high_setpt);
         remote_ot_reg   <= $signed(i_remote_temp) > $signed(i_remote_ot_setpt);
      end
   end

   // Sticky flags: a live fault beats the read clear so none is lost
   always @* begin
      alarm_status_next = alarm_status_reg;
      if (rd_status)
         alarm_status_next = `FAN_RST_ALARM_STATUS;
      if (remote_high_reg)
         alarm_status_next[`FAN_ST_REMOTE_HIGH] = 1'b1;
      if (remote_ot_reg)
         alarm_status_next[`FAN_ST_REMOTE_OT] = 1'b1;
      if (fan_b_fault)
         alarm_status_next[`FAN_ST_FAN_B] = 1'b1;
      if (fan_a_fault)
         alarm_status_next[`FAN_ST_FAN_A] = 1'b1;
      alarm_status_next[7:4] = 4'h0;
   end

   always @(posedge i_ref_clk) begin
      if (i_srst)
         alarm_status_reg <= `FAN_RST_ALARM_STATUS;
      else
         alarm_status_reg <= alarm_status_next;
   end

   // APB register side and read data
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         nvm_xfer_ctrl_reg <= `FAN_RST_NVM_XFER_CTRL;
         mode_reg          <= `FAN_RST_MODE;
         o_prdata          <= 32'h0000_0000;
         o_pready          <= 1'b0;
         o_pslverr         <= 1'b0;
      end else begin
         // One wait state: ready rises in the second access cycle
         o_pready  <= i_psel & i_penable & ~o_pready;
         o_pslverr <= i_psel & i_penable & ~o_pready & ~mapped;
         if (i_psel & i_penable & ~o_pready & ~i_pwrite) begin
            case (i_paddr[9:0])
               `FAN_ADDR_ALARM_STATUS:  o_prdata <= {24'h000000, alarm_status_reg};
               `FAN_ADDR_NVM_XFER_CTRL: o_prdata <= {24'h000000, nvm_xfer_ctrl_reg};
               `FAN_ADDR_MODE:          o_prdata <= {30'h00000000, mode_reg};
               `FAN_ADDR_XFER_STATUS:   o_prdata <= {31'h00000000, state_reg != ST_IDLE};
               default:                 o_prdata <= 32'h0000_0000;
            endcase
            if (i_paddr[11:10] != 2'h0)
               o_prdata <= 32'h0000_0000;
         end
         if (rd_ctrl)
            nvm_xfer_ctrl_reg <= `FAN_RST_NVM_XFER_CTRL;
         else if (wr_ctrl)
            nvm_xfer_ctrl_reg <= {i_pwdata[7], 2'b00, i_pwdata[4:0]};
         if (access & i_pwrite & (i_paddr[9:0] == `FAN_ADDR_MODE))
            mode_reg <= i_pwdata[1:0];
      end
   end

   // Transfer engine: walks selected blocks, one byte per ready handshake
   always @(posedge i_ref_clk) begin
      if (i_srst) begin
         state_reg    <= ST_IDLE;
         blk_mask_reg <= 5'h00;
         blk_reg      <= 3'h0;
         byte_reg     <= 4'h0;
         o_nvm_req    <= 1'b0;
         o_nvm_load   <= 1'b0;
         o_nvm_addr   <= 7'h00;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               o_nvm_req <= 1'b0;
               if (wr_ctrl && (i_pwdata[`FAN_XC_BLK_MSB:`FAN_XC_BLK_LSB] != 5'h00)) begin
                  blk_mask_reg <= i_pwdata[`FAN_XC_BLK_MSB:`FAN_XC_BLK_LSB];
                  o_nvm_load   <= i_pwdata[`FAN_XC_DIR];
                  blk_reg      <= 3'h0;
                  state_reg    <= ST_NEXT;
               end
            end
            ST_NEXT: begin
               if (blk_reg == `FAN_BLOCK_COUNT) begin
                  state_reg <= ST_IDLE;
               end else if (blk_mask_reg[blk_reg]) begin
                  byte_reg   <= 4'h0;
                  o_nvm_addr <= {blk_reg, 4'h0};
                  o_nvm_req  <= 1'b1;
                  state_reg  <= ST_MOVE;
               end else begin
                  blk_reg <= blk_reg + 3'h1;
               end
            end
            ST_MOVE: begin
               if (i_nvm_ready) begin
                  if (byte_reg == 4'hF) begin
                     o_nvm_req <= 1'b0;
                     blk_reg   <= blk_reg + 3'h1;
                     state_reg <= ST_NEXT;
                  end else begin
                     byte_reg   <= byte_reg + 4'h1;
                     o_nvm_addr <= {blk_reg, byte_reg + 4'h1};
                  end
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end
endmodule // fan_alarm_bank
`default_nettype wire

// >>> sim/fan_alarm_bank_properties.sv
// Port-level assertions for the fan alarm and NVM transfer bank
`timescale 1ns/1ns
`default_nettype none
module fan_alarm_bank_properties #(
   parameter TW = 12
) (
   // Clock, reset and APB
   input wire logic          i_ref_clk,
   input wire logic          i_srst,
   input wire logic          i_psel,
   input wire logic          i_penable,
   input wire logic          i_pwrite,
   input wire logic [11:0]   i_paddr,
   input wire logic [31:0]   o_prdata,
   input wire logic          o_pready,
   input wire logic          o_pslverr,
   // Alarm sources and transfer engine
   input wire logic [TW-1:0] i_remote_temp,
   input wire logic [TW-1:0] i_remote_high_setpt,
   input wire logic [TW-1:0] i_remote_ot_setpt,
   input wire logic          i_fan_a_stopped,
   input wire logic          i_fan_a_speed_input,
   input wire logic          i_nvm_ready,
   input wire logic          o_nvm_req,
   input wire logic [6:0]    o_nvm_addr
);
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_srst);
   wire st_rd = o_pready && !i_pwrite && i_paddr == 12'h168;
   // Four steady cycles cover the two-edge flag pipeline
   sequence s_hot_hi; ($signed(i_remote_temp) > $signed(i_remote_high_setpt)) [*4]; endsequence
   sequence s_hot_ot; ($signed(i_remote_temp) > $signed(i_remote_ot_setpt)) [*4]; endsequence
   sequence s_fan_dead; (i_fan_a_stopped && !i_fan_a_speed_input) [*4]; endsequence
   chk_remote_high: assert property (s_hot_hi ##1 st_rd |-> o_prdata[3])
      else $error("Remote high flag missing");
   chk_remote_ot: assert property (s_hot_ot ##1 st_rd |-> o_prdata[2])
      else $error("Remote overtemp flag missing");
   chk_fan_dead: assert property (s_fan_dead ##1 st_rd |-> o_prdata[0])
      else $error("Fan A fault flag missing");
   chk_ctrl_rsv: assert property (o_pready && !i_pwrite && i_paddr == 12'h16C |->
      o_prdata[6:5] == 2'b00) else $error("Reserved control bits read set");
   chk_blk_start: assert property ($rose(o_nvm_req) |-> o_nvm_addr[3:0] == 4'h0)
      else $error("Block does not start at its first byte");
   chk_addr_step: assert property (o_nvm_req && i_nvm_ready && o_nvm_addr[3:0] != 4'hF
      |=> o_nvm_req && o_nvm_addr == $past(o_nvm_addr) + 7'h01)
      else $error("Transfer address did not advance");
   chk_addr_hold: assert property (o_nvm_req && !i_nvm_ready
      |=> o_nvm_req && $stable(o_nvm_addr)) else $error("Address moved while stalled");
   chk_blk_gap: assert property (o_nvm_req && i_nvm_ready && o_nvm_addr[3:0] == 4'hF
      |=> !o_nvm_req) else $error("No idle cycle after block");
   chk_addr_range: assert property (o_nvm_req |-> o_nvm_addr <= 7'h4F)
      else $error("Transfer address beyond last block");
   chk_answer_time: assert property (i_psel && !i_penable |-> ##2 o_pready)
      else $error("APB answer not after one wait state");
   chk_bad_addr: assert property (o_pready && !(i_paddr inside {12'h168, 12'h16C, 12'h170,
      12'h174}) |-> o_pslverr && (i_pwrite || o_prdata == 32'h0))
      else $error("Unmapped access not refused");
endmodule // fan_alarm_bank_properties
bind fan_alarm_bank fan_alarm_bank_properties #(.TW(TW)) u_props (
   .i_ref_clk(i_ref_clk), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .o_prdata(o_prdata), .o_pready(o_pready),
   .o_pslverr(o_pslverr), .i_remote_temp(i_remote_temp),
   .i_remote_high_setpt(i_remote_high_setpt), .i_remote_ot_setpt(i_remote_ot_setpt),
   .i_fan_a_stopped(i_fan_a_stopped), .i_fan_a_speed_input(i_fan_a_speed_input),
   .i_nvm_ready(i_nvm_ready), .o_nvm_req(o_nvm_req), .o_nvm_addr(o_nvm_addr));
`default_nettype wire

// >>> sim/fan_alarm_bank_tb_top.sv
// Self-checking bench for the fan alarm and NVM transfer bank
`timescale 1ns/1ns
`default_nettype none
`include "fan_regs.vh"
module fan_alarm_bank_tb_top;
   logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, rdy = 0, er;
   logic        a_v = 0, b_v = 0, b_ov = 0, a_st = 0, a_sp = 0, b_sp = 0;
   logic        a_ov = 0, b_st = 0;
   logic        pready, pslverr, req, load;
   logic [11:0] paddr = 0, temp = 0;
   logic [31:0] pwdata = 0, prdata, rd;
   logic [15:0] a_cnt = 0, b_cnt = 0;
   logic [6:0]  addr;
   logic [7:0]  seen [$];
   int          mismatches = 0, num_checks = 0;
   localparam logic [11:0] ST = `FAN_ADDR_ALARM_STATUS, XC = `FAN_ADDR_NVM_XFER_CTRL;
   localparam logic [15:0] THR = 16'h0100;
   fan_alarm_bank u_dut (
      .i_ref_clk(clk), .i_srst(srst), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr),
      .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(pslverr), .i_remote_temp(temp), .i_remote_high_setpt(12'h064),
      .i_remote_ot_setpt(12'h0C8), .i_fan_a_count(a_cnt), .i_fan_a_count_valid(a_v),
      .i_fan_a_overflow(a_ov), .i_fan_a_stopped(a_st), .i_fan_a_speed_input(a_sp),
      .i_fan_b_count(b_cnt), .i_fan_b_count_valid(b_v), .i_fan_b_overflow(b_ov),
      .i_fan_b_stopped(b_st), .i_fan_b_speed_input(b_sp), .i_tach_threshold(THR),
      .i_nvm_ready(rdy), .o_nvm_req(req), .o_nvm_load(load), .o_nvm_addr(addr));
   always #10 clk = ~clk;
   // Alternate stalls so every byte after the first of a block sees a held address
   always @(posedge clk) rdy <= ~rdy;
   always @(posedge clk) if (req === 1'b1 && rdy === 1'b1) seen.push_back({load, addr});
   task conclude;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      @(posedge clk); psel <= 1'b1; pen <= 1'b0; pwr <= w; paddr <= a; pwdata <= d;
      @(posedge clk); pen <= 1'b1;
      n = 0;
      do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
      rd = prdata;
      er = pslverr;
      if (n >= 20) begin mismatches++; conclude; end
      psel <= 1'b0; pen <= 1'b0;
   endtask
   task rd_chk(input logic [11:0] a, input logic [31:0] e); apb(0, a, 0); chk(rd, e); endtask
   task waitc(input int n); repeat (n) @(posedge clk); endtask
   // First read drops flags latched by earlier stimulus
   task settle(input logic [7:0] e); waitc(4); apb(0, ST, 0); rd_chk(ST, e); endtask
   task pulse; @(posedge clk); a_v <= 1'b1; b_v <= 1'b1; @(posedge clk); a_v <= 1'b0; b_v <= 1'b0;
   endtask
   task t_reset;
      rd_chk(XC, 32'h0);
      rd_chk(ST, 32'h0);
      rd_chk(`FAN_ADDR_MODE, 32'h0);
      apb(0, 12'h178, 0); chk(er, 1);
      // Aliased control offset: refused, no transfer, register untouched
      apb(1, 12'h400 | XC, 32'h1F); chk(er, 1);
      rd_chk(XC, 32'h0);
   endtask
   task t_temp;
      temp <= 12'h096; settle(8'h08);
      temp <= 12'h0FA; waitc(4); rd_chk(ST, 8'h0C);
      rd_chk(ST, 8'h0C);
      temp <= 12'h0C8; waitc(4); rd_chk(ST, 8'h0C);
      rd_chk(ST, 8'h08);
      temp <= 12'hF00; settle(8'h00);
   endtask
   task t_fan;
      a_cnt <= THR; b_cnt <= THR; pulse; settle(8'h00);
      a_cnt <= THR + 16'h0001; pulse; settle(8'h01);
      a_cnt <= THR; b_ov <= 1'b1; pulse; settle(8'h02);
      b_ov <= 1'b0; a_st <= 1'b1; pulse; settle(8'h01);
      a_st <= 1'b0; a_ov <= 1'b1; b_st <= 1'b1; pulse; settle(8'h03);
      a_ov <= 1'b0; b_st <= 1'b0; apb(1, `FAN_ADDR_MODE, 32'h3);
      a_sp <= 1'b1; b_sp <= 1'b1; settle(8'h00);
      a_sp <= 1'b0; settle(8'h01);
   endtask
   task xfer(input logic [7:0] w);
      int n, k, cnt;
      seen.delete();
      cnt = 16 * $countones(w[4:0]);
      apb(1, XC, {24'h0, w});
      rd_chk(XC, w & 8'h9F);
      rd_chk(XC, 32'h0);
      n = 0;
      while (seen.size() < cnt && n < 400) begin @(posedge clk); n++; end
      if (n >= 400) begin mismatches++; conclude; end
      waitc(40);
      chk(seen.size(), cnt);
      k = 0;
      for (int b = 0; b < 5; b++) if (w[b]) for (int i = 0; i < 16; i++) begin
         chk(seen[k], {w[7], b[2:0], i[3:0]});
         k++;
      end
   endtask
   initial begin
      repeat (3) @(posedge clk);
      srst <= 1'b0;
      t_reset;
      t_temp;
      t_fan;
      xfer(8'hF5);
      xfer(8'h60);
      xfer(8'h02);
      conclude;
   end
endmodule // fan_alarm_bank_tb_top
`default_nettype wire
